/* File: rtl/tpc_pkg.sv */
// Constants shared by the threshold persistence and configuration block.
// Assumes a 125 MHz core clock and 8-bit register accesses.
package tpc_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [7:0] TPC_INTERRUPT_PERSISTENCE_ADDR  = 8'h8c;
   localparam logic [7:0] TPC_GENERAL_CONFIG_ZERO_ADDR  = 8'h8d;
   localparam logic [7:0] TPC_INTERRUPT_PERSISTENCE_RST   = 8'h00;
   localparam logic [7:0] TPC_GENERAL_CONFIG_ZERO_RST   = 8'h00;
   localparam logic [7:0] TPC_GENERAL_CONFIG_ZERO_MASK  = 8'h27; // Reserved bits read zero
   localparam logic [7:0] TPC_READ_NONE  = 8'h00;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int TPC_PROX_LSB    = 4;
   localparam int TPC_LIGHT_LSB   = 0;
   localparam int TPC_IDLE_BIT    = 5;
   localparam int TPC_STRETCH_BIT = 2;
   localparam int TPC_PAGE_LSB    = 0;
   localparam int TPC_CODE_W      = 4;
   localparam int TPC_PAGE_W      = 2;

   // Pattern memory page values
   localparam logic [1:0] TPC_PAGE_LOW   = 2'h0;
   localparam logic [1:0] TPC_PAGE_HIGH  = 2'h1;
   localparam logic [1:0] TPC_PAGE_WORDS = 2'h2;
   localparam logic [7:0] TPC_WORD_BASE  = 8'hb0;

   // ****************************************************
   // Persistence counters
   // ****************************************************
   localparam int              TPC_CNT_W      = 6;
   localparam logic [5:0]      TPC_CNT_MAX    = 6'h3f;
   localparam logic [3:0]      TPC_LIGHT_KNEE = 4'h3;
   localparam logic [5:0]      TPC_LIGHT_STEP = 6'h05;

   // ****************************************************
   // Wait timing
   // ****************************************************
   localparam int         TPC_CLK_PS        = 8000;
   localparam longint     TPC_WAIT_UNIT_PS  = 64'd2780000000; // Too large for a 32-bit int
   localparam longint     TPC_WAIT_LONG_PS  = 64'd33300000000;
   localparam int         TPC_WAIT_UNIT_CYC = int'(TPC_WAIT_UNIT_PS / TPC_CLK_PS);
   localparam int         TPC_WAIT_LONG_CYC = int'(TPC_WAIT_LONG_PS / TPC_CLK_PS);
   localparam int         TPC_UNIT_W        = 23;
   localparam logic [8:0] TPC_WAIT_BASE     = 9'h100;

   typedef enum logic {TPC_W_IDLE, TPC_W_RUN} tpc_wait_e;

   // Light code to sample count: linear to the knee, then steps of five
   function automatic logic [5:0] tpc_light_target(input logic [3:0] code);
      logic [5:0] diff;
      diff = {2'h0, code - TPC_LIGHT_KNEE};
      if (code <= TPC_LIGHT_KNEE)
         tpc_light_target = {2'h0, code};
      else
         tpc_light_target = 6'(diff * TPC_LIGHT_STEP);
   endfunction

endpackage

/* File: rtl/tpc_persist_filter.sv */
// One persistence filter: counts consecutive out-of-window samples.
// Assumes sample_done is a one-cycle pulse on the core clock.
`timescale 1ns/1ns
module tpc_persist_filter
#(
   parameter int CNT_W = tpc_pkg::TPC_CNT_W
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             sample_done,
   input  wire logic [15:0]      result,
   input  wire logic [15:0]      low_limit,
   input  wire logic [15:0]      high_limit,
   input  wire logic [CNT_W-1:0] target,
   output logic                  out_of_range,
   output logic [CNT_W-1:0]      count_r,
   output logic                  irq_r
);
   import tpc_pkg::*;

   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] cnt_max;

   // ****************************************************
   // Window compare and counter update
   // ****************************************************
   assign cnt_max      = {CNT_W{1'b1}};
   assign out_of_range = (result < low_limit) || (result > high_limit);

   // Saturate so a long excursion never wraps back under the target
   always_comb
   begin
      if (!out_of_range)
         count_nxt = '0;
      else if (count_r == cnt_max)
         count_nxt = count_r;
      else
         count_nxt = count_r + 1'b1;
   end

   // Counter moves only on a completed measurement
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count_r <= '0;
      else if (sample_done)
         count_r <= count_nxt;
   end

   // Zero target fires every cycle; otherwise the run must reach it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_r <= 1'b0;
      else
         irq_r <= sample_done &&
                  ((target == '0) ||
                   (out_of_range && count_nxt >= target));
   end

endmodule

/* File: rtl/tpc_config_regs.sv */
// Persistence and general configuration registers with their filters,
// wait timer, idle power request and pattern page steering.
// Assumes an 8-bit register port from the serial host interface and
// measurement strobes from sensor logic on the same clock.
`timescale 1ns/1ns

// What this block does
// - Prox interrupt after count reaches persistence setting
// - In-window prox result clears prox counter
// - Prox setting zero: interrupt every cycle
// - Prox settings 1-15 need that many
// - Separate light counter, cleared inside window
// - Light code zero: interrupt every cycle
// - Light codes 1-3 direct, then 5x(code-3)
// - Idle bit: low power when all idle
// - Stretch bit makes wait twelve times longer
// - Page 0 lower, page 1 upper half
// - Page 2 reaches sixteen pattern words
// - Wait is unit times 256 minus count
// - Light pin needs enable and persistence met
module tpc_config_regs
import tpc_pkg::*;
#(
   parameter int WAIT_UNIT_CYC = tpc_pkg::TPC_WAIT_UNIT_CYC,
   parameter int WAIT_LONG_CYC = tpc_pkg::TPC_WAIT_LONG_CYC
)
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_rd,
   output logic [7:0]                  reg_rdata_r,
   input  wire logic                   prox_done,
   input  wire logic [15:0]            prox_result,
   input  wire logic [15:0]            prox_low_limit,
   input  wire logic [15:0]            prox_high_limit,
   input  wire logic                   light_done,
   input  wire logic [15:0]            clear_channel_result,
   input  wire logic [15:0]            light_low_limit,
   input  wire logic [15:0]            light_high_limit,
   input  wire logic                   light_irq_enable,
   input  wire logic [7:0]             wait_period_count,
   input  wire logic                   wait_start,
   input  wire logic                   prox_busy,
   input  wire logic                   light_busy,
   input  wire logic [6:0]             pattern_offset,
   output logic                        prox_irq,
   output logic                        light_irq,
   output logic                        wait_active,
   output logic                        wait_done,
   output logic                        idle_power_saving,
   output logic [7:0]                  pattern_mem_addr,
   output logic                        pattern_word_access,
   output logic [TPC_CNT_W-1:0]        prox_count,
   output logic [TPC_CNT_W-1:0]        light_count
);
   import tpc_pkg::*;

   // ****************************************************
   // Registers
   // ****************************************************
   logic [7:0]            interrupt_persistence_r;
   logic [7:0]            general_config_zero_r;
   logic [3:0]            prox_persist_count;
   logic [3:0]            light_persist_code;
   logic                  idle_bit;
   logic                  wait_stretch;
   logic [TPC_PAGE_W-1:0] page_sel;
   logic [TPC_CNT_W-1:0]  prox_target;
   logic [TPC_CNT_W-1:0]  light_target;
   logic                  prox_out;
   logic                  light_out;
   logic                  light_met;

   assign prox_persist_count = interrupt_persistence_r[TPC_PROX_LSB +: TPC_CODE_W];
   assign light_persist_code = interrupt_persistence_r[TPC_LIGHT_LSB +: TPC_CODE_W];
   assign idle_bit           = general_config_zero_r[TPC_IDLE_BIT];
   assign wait_stretch       = general_config_zero_r[TPC_STRETCH_BIT];
   assign page_sel           = general_config_zero_r[TPC_PAGE_LSB +: TPC_PAGE_W];

   // Persistence register write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         interrupt_persistence_r <= TPC_INTERRUPT_PERSISTENCE_RST;
      else if (reg_wr && reg_addr == TPC_INTERRUPT_PERSISTENCE_ADDR)
         interrupt_persistence_r <= reg_wdata;
   end

   // Config register write; reserved bits never stored
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         general_config_zero_r <= TPC_GENERAL_CONFIG_ZERO_RST;
      else if (reg_wr && reg_addr == TPC_GENERAL_CONFIG_ZERO_ADDR)
         general_config_zero_r <= reg_wdata & TPC_GENERAL_CONFIG_ZERO_MASK;
   end

   // Registered read; unmapped offsets answer zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_r <= TPC_READ_NONE;
      else if (reg_rd)
      begin
         case (reg_addr)
            TPC_INTERRUPT_PERSISTENCE_ADDR: reg_rdata_r <= interrupt_persistence_r;
            TPC_GENERAL_CONFIG_ZERO_ADDR: reg_rdata_r <= general_config_zero_r;
            default:       reg_rdata_r <= TPC_READ_NONE;
         endcase
      end
   end

   // ****************************************************
   // Persistence filters
   // ****************************************************
   assign prox_target  = {2'h0, prox_persist_count};
   assign light_target = tpc_light_target(light_persist_code);

   tpc_persist_filter #(.CNT_W(TPC_CNT_W)) u_prox_filter
   (
      .clk          (clk),
      .rst_n        (rst_n),
      .sample_done  (prox_done),
      .result       (prox_result),
      .low_limit    (prox_low_limit),
      .high_limit   (prox_high_limit),
      .target       (prox_target),
      .out_of_range (prox_out),
      .count_r      (prox_count),
      .irq_r        (prox_irq)
   );

   tpc_persist_filter #(.CNT_W(TPC_CNT_W)) u_light_filter
   (
      .clk          (clk),
      .rst_n        (rst_n),
      .sample_done  (light_done),
      .result       (clear_channel_result),
      .low_limit    (light_low_limit),
      .high_limit   (light_high_limit),
      .target       (light_target),
      .out_of_range (light_out),
      .count_r      (light_count),
      .irq_r        (light_met)
   );

   // Pin request only while software allows it
   assign light_irq = light_met && light_irq_enable;

   // ****************************************************
   // Wait timer
   // ****************************************************
   tpc_wait_e              wait_state_r;
   logic [TPC_UNIT_W-1:0]  unit_cnt_r;
   logic [8:0]             steps_r;
   logic                   long_r;
   logic [TPC_UNIT_W-1:0]  unit_last;
   logic                   unit_end;

   // Stretch is latched at start so a mid-wait write cannot split a unit
   assign unit_last = long_r ? TPC_UNIT_W'(WAIT_LONG_CYC - 1)
                             : TPC_UNIT_W'(WAIT_UNIT_CYC - 1);
   assign unit_end  = (unit_cnt_r == unit_last);

   // Wait state machine
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_state_r <= TPC_W_IDLE;
         unit_cnt_r   <= '0;
         steps_r      <= '0;
         long_r       <= 1'b0;
         wait_done    <= 1'b0;
      end
      else
      begin
         wait_done <= 1'b0;
         case (wait_state_r)
            TPC_W_IDLE:
            begin
               if (wait_start)
               begin
                  steps_r      <= TPC_WAIT_BASE - {1'b0, wait_period_count};
                  long_r       <= wait_stretch;
                  unit_cnt_r   <= '0;
                  wait_state_r <= TPC_W_RUN;
               end
            end
            TPC_W_RUN:
            begin
               if (unit_end)
               begin
                  unit_cnt_r <= '0;
                  steps_r    <= steps_r - 1'b1;
                  if (steps_r == 9'h001)
                  begin
                     wait_done    <= 1'b1;
                     wait_state_r <= TPC_W_IDLE;
                  end
               end
               else
                  unit_cnt_r <= unit_cnt_r + 1'b1;
            end
            default: wait_state_r <= TPC_W_IDLE;
         endcase
      end
   end

   assign wait_active = (wait_state_r == TPC_W_RUN);

   // ****************************************************
   // Idle power and pattern page
   // ****************************************************
   // Busy means enabled and not waiting; sensors report it directly
   assign idle_power_saving = idle_bit && !prox_busy && !light_busy;

   // Pages 0 and 1 pick a half; page 2 and up open the word window
   assign pattern_word_access = (page_sel >= TPC_PAGE_WORDS);
   assign pattern_mem_addr    = pattern_word_access
                                ? (TPC_WORD_BASE | {4'h0, pattern_offset[3:0]})
                                : {page_sel[0], pattern_offset};

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wait_begin;
      wait_state_r == TPC_W_IDLE && wait_start;
   endsequence

   sequence s_wait_unit_one;
      wait_active && unit_cnt_r == '0;
   endsequence

   a_prox_every_cycle: assert property (
      prox_done && prox_persist_count == 4'h0 |=> prox_irq)
      else $error("prox interrupt missing with zero setting");

   a_prox_in_window: assert property (
      prox_done && !prox_out |=> prox_count == '0 && !(prox_irq && $past(prox_target) != '0))
      else $error("prox counter not cleared inside window");

   a_prox_reach: assert property (
      prox_irq && $past(prox_target) != '0 |-> prox_count >= $past(prox_target))
      else $error("prox interrupt before persistence reached");

   a_prox_needs_done: assert property (
      prox_irq |-> $past(prox_done))
      else $error("prox interrupt without a measurement");

   a_light_clear: assert property (
      light_done && !light_out |=> light_count == '0)
      else $error("light counter not cleared inside window");

   a_light_every: assert property (
      light_done && light_persist_code == 4'h0 |=> light_met)
      else $error("light interrupt missing with zero code");

   a_light_map: assert property (
      light_persist_code == 4'hf |-> light_target == 6'd60)
      else $error("light code fifteen does not map to sixty");

   a_light_gate: assert property (
      light_irq |-> light_irq_enable && light_met)
      else $error("light pin asserted while disabled");

   a_count_sat: assert property (
      light_done && light_out && light_count == TPC_CNT_MAX |=> light_count == TPC_CNT_MAX)
      else $error("light counter wrapped");

   a_count_hold: assert property (
      !prox_done |=> $stable(prox_count))
      else $error("prox counter moved without a measurement");

   a_wait_start: assert property (
      s_wait_begin |=> s_wait_unit_one ##0 long_r == $past(wait_stretch))
      else $error("wait did not start with latched stretch");

   a_idle_power: assert property (
      idle_power_saving |-> idle_bit && !prox_busy && !light_busy)
      else $error("idle power without all functions idle");

   a_page_half: assert property (
      page_sel == TPC_PAGE_HIGH |-> pattern_mem_addr[7] && !pattern_word_access)
      else $error("upper page not selected");

   a_page_words: assert property (
      page_sel == TPC_PAGE_WORDS |-> pattern_mem_addr[7:4] == TPC_WORD_BASE[7:4])
      else $error("word window not selected");

   a_page_low: assert property (
      page_sel == TPC_PAGE_LOW |-> pattern_mem_addr == {1'b0, pattern_offset})
      else $error("lower page not selected");

   a_wait_refused: assert property (
      wait_active && !unit_end && wait_start |=> wait_active && unit_cnt_r == $past(unit_cnt_r) + 1'b1)
      else $error("wait restarted while running");

   a_wait_pulse: assert property (
      wait_done |-> !wait_active ##1 !wait_done)
      else $error("wait done not a single pulse");

endmodule

/* File: dv/tpc_host_model.sv */
// Host side model: issues register writes and reads to the config block.
// Assumes the shared core clock; tasks are entered just after a rising edge.
`timescale 1ns/1ns
module tpc_host_model
(
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata_r,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   output logic            reg_rd
);
   // Idle strobes low at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // Write: held over one taking edge, then the bus shows inverted junk
   // An edge passes first so back-to-back calls never reassign a strobe at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // Read: data lands at the taking edge, sampled once it settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      d = reg_rdata_r;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the persistence and configuration block.
// Assumes the host model in dv/ and short wait units for run length.
`timescale 1ns/1ns
module testbench;
   import tpc_pkg::*;
   localparam int U = 4;
   localparam int UL = 48;
   logic clk = 1'b0, rst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_r, wait_period_count = 8'h00, pattern_mem_addr, rv;
   logic reg_wr, reg_rd, prox_done = 1'b0, light_done = 1'b0, light_irq_enable = 1'b0;
   logic wait_start = 1'b0, prox_busy = 1'b0, light_busy = 1'b0;
   logic [15:0] prox_result = 16'h0, clear_channel_result = 16'h0;
   logic [15:0] lo_lim = 16'h1000, hi_lim = 16'h2000;
   logic [6:0] pattern_offset = 7'h00;
   logic prox_irq, light_irq, wait_active, wait_done, idle_power_saving, pattern_word_access;
   logic [5:0] prox_count, light_count;
   logic [5:0] ec [2];
   int bad_count = 0, compares = 0;

   // ****************************************************
   // Clock, host model and design
   // ****************************************************
   always #4 clk = ~clk;

   tpc_host_model i_host (.clk(clk), .reg_rdata_r(reg_rdata_r), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd));

   tpc_config_regs #(.WAIT_UNIT_CYC(U), .WAIT_LONG_CYC(UL)) i_dut (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .prox_done(prox_done), .prox_result(prox_result), .prox_low_limit(lo_lim), .prox_high_limit(hi_lim),
      .light_done(light_done), .clear_channel_result(clear_channel_result), .light_low_limit(lo_lim),
      .light_high_limit(hi_lim), .light_irq_enable(light_irq_enable), .wait_period_count(wait_period_count),
      .wait_start(wait_start), .prox_busy(prox_busy), .light_busy(light_busy), .pattern_offset(pattern_offset),
      .prox_irq(prox_irq), .light_irq(light_irq), .wait_active(wait_active), .wait_done(wait_done),
      .idle_power_saving(idle_power_saving), .pattern_mem_addr(pattern_mem_addr),
      .pattern_word_access(pattern_word_access), .prox_count(prox_count), .light_count(light_count));

   // ****************************************************
   // Compare, expectation and closing helpers
   // ****************************************************
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h0, got}, {7'h0, exp});
   endtask

   // Samples needed for a light code: direct up to three, then steps of five
   function automatic logic [5:0] light_need(input logic [3:0] c);
      return (c <= 4'h3) ? {2'h0, c} : 6'((c - 4'h3) * 5);
   endfunction

   task automatic results();
      $display("compares=%0d mismatches=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One measurement on channel ch (0 prox, 1 light); limits avoid the boundary values
   task automatic step(input int ch, input logic out, input logic [5:0] tgt);
      logic [15:0] r;
      r = 16'h1001 + 16'($urandom % 4095);
      if (out)
         r = ($urandom % 2) ? 16'h2001 + 16'($urandom % 256) : 16'($urandom % 4095);
      prox_result = r;
      clear_channel_result = r;
      if (ch == 0)
         prox_done = 1'b1;
      else
         light_done = 1'b1;
      @(posedge clk);
      #1;
      prox_done = 1'b0;
      light_done = 1'b0;
      ec[ch] = out ? ((ec[ch] == 6'h3f) ? ec[ch] : ec[ch] + 6'h01) : 6'h00;
      chk_byte({2'h0, (ch == 1) ? light_count : prox_count}, {2'h0, ec[ch]});
      chk_bit((ch == 1) ? light_irq : prox_irq,
         (tgt == 6'h0 || (out && ec[ch] >= tgt)) && (ch == 0 || light_irq_enable));
      // Gap edge, so the next strobe is a fresh pulse and not a double assignment
      @(posedge clk);
      #1;
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      int n, bound;
      logic [3:0] c;
      logic [7:0] cnt;
      void'($urandom(32'hd30c27da));
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // Reset values, reserved bits and an unmapped address
      i_host.rd(TPC_INTERRUPT_PERSISTENCE_ADDR, rv);
      chk_byte(rv, TPC_INTERRUPT_PERSISTENCE_RST);
      i_host.rd(TPC_GENERAL_CONFIG_ZERO_ADDR, rv);
      chk_byte(rv, TPC_GENERAL_CONFIG_ZERO_RST);
      i_host.wr(TPC_GENERAL_CONFIG_ZERO_ADDR, 8'hff);
      i_host.rd(TPC_GENERAL_CONFIG_ZERO_ADDR, rv);
      chk_byte(rv, 8'h27);
      i_host.rd(8'h8e, rv);
      chk_byte(rv, 8'h00);
      $display("test registers done");
      // Every persistence code on both channels, random result values
      for (int k = 0; k < 16; k++)
      begin
         c = 4'(k);
         light_irq_enable = 1'($urandom % 2);
         i_host.wr(TPC_INTERRUPT_PERSISTENCE_ADDR, {c, c});
         i_host.rd(TPC_INTERRUPT_PERSISTENCE_ADDR, rv);
         chk_byte(rv, {c, c});
         step(0, 1'b0, {2'h0, c});
         step(1, 1'b0, light_need(c));
         repeat (int'(c) + 2) step(0, 1'b1, {2'h0, c});
         repeat (int'(light_need(c)) + 2) step(1, 1'b1, light_need(c));
         step(0, 1'b0, {2'h0, c});
      end
      // Saturation on the light counter, then the enable gate
      light_irq_enable = 1'b1;
      repeat (6) step(1, 1'b1, 6'd60);
      light_irq_enable = 1'b0;
      step(1, 1'b1, 6'd60);
      $display("test persistence done");
      // Page steering for all four codes
      for (int p = 0; p < 4; p++)
      begin
         pattern_offset = 7'($urandom);
         i_host.wr(TPC_GENERAL_CONFIG_ZERO_ADDR, 8'(p));
         chk_byte(pattern_mem_addr, (p >= 2) ? (8'hb0 | {4'h0, pattern_offset[3:0]}) :
            {p[0], pattern_offset});
         chk_bit(pattern_word_access, p >= 2);
      end
      $display("test page done");
      // Idle request against every busy combination
      for (int i = 0; i < 8; i++)
      begin
         i_host.wr(TPC_GENERAL_CONFIG_ZERO_ADDR, {2'h0, i[2], 5'h0});
         prox_busy = i[1];
         light_busy = i[0];
         #1;
         chk_bit(idle_power_saving, i[2] & ~i[1] & ~i[0]);
      end
      $display("test idle done");
      // Wait timer, normal and stretched, with a refused restart mid-wait
      for (int l = 0; l < 2; l++)
      begin
         i_host.wr(TPC_GENERAL_CONFIG_ZERO_ADDR, {5'h0, l[0], 2'h0});
         cnt = (l == 1) ? (8'hf8 | 8'($urandom % 8)) : 8'($urandom);
         wait_period_count = cnt;
         bound = (256 - int'(cnt)) * ((l == 1) ? UL : U) + 1;
         wait_start = 1'b1;
         @(posedge clk);
         #1;
         wait_period_count = 8'hff;
         n = 1;
         while (wait_done !== 1'b1 && n < bound + 10)
         begin
            if (n == 3)
               wait_start = 1'b1;
            else
               wait_start = 1'b0;
            @(posedge clk);
            #1;
            n++;
         end
         if (wait_done !== 1'b1)
         begin
            bad_count++;
            results();
         end
         chk_byte(8'(n), 8'(bound));
         chk_byte(8'(n >> 8), 8'(bound >> 8));
         chk_bit(wait_active, 1'b0);
      end
      $display("test wait done");
      results();
   end
endmodule
